/* File: verilog/cluster_power_control_regs.sv */
// Cluster power control, powerdown requirement and power status registers
`timescale 1ns/1ps
// Function
// - 3-bit retention timeout, zero disables, resets zero
// - Codes 1-7 mean 2..512 timer ticks
// - Cache portion request drives hint bits 19:16
// - Powerdown requirement banked per thread
// - Bit 1 advertises memory retention need
// - Bit 0 advertises cluster power need
// - Hints advisory; powerdown requests always accepted
// - Per-thread powerdown bits reset to zero
// - Status 7:4 reports powered cache portions
// - Portion status reset follows channel init
// - Status bit 1 combines retention bits
// - Status bit 0 combines cluster power bits
// - Status register read-only, shared, writes ignored
// - Kernel writes gated by enables and security
// - Registers at CRn 15 CRm 3 op2 5-7
module cluster_power_control_regs
    import cluster_power_pkg::*;
(
    input  wire logic                I_CLK,
    input  wire logic                I_ARST_N,
    input  wire logic                I_REG_VALID,
    input  wire logic                I_REG_WRITE,
    input  wire logic [3:0]          I_REG_CRN,
    input  wire logic [3:0]          I_REG_CRM,
    input  wire logic [2:0]          I_REG_OP2,
    input  wire logic [THREAD_W-1:0] I_REG_THREAD,
    input  wire logic [1:0]          I_REG_EL,
    input  wire logic [31:0]         I_REG_WDATA,
    input  wire logic                I_TOP_PWR_WE,
    input  wire logic                I_HYP_PWR_WE,
    input  wire logic                I_NONSECURE,
    input  wire logic                I_TIMER_TICK,
    input  wire logic                I_CLUSTER_ACTIVE,
    input  wire logic [3:0]          I_PCH_INIT_PORTIONS,
    input  wire logic [3:0]          I_PORTIONS_POWERED,
    input  wire logic                I_PCH_DOWN_REQ,
    output logic [31:0]              O_REG_RDATA,
    output logic                     O_REG_ACK,
    output logic                     O_REG_FAULT,
    output logic                     O_PCH_DOWN_ACCEPT,
    output logic [HINT_W-1:0]        O_POWER_ACTIVE_HINT
);

    // ==========================================================
    // Helpers
    function automatic logic is_pwr_reg(input logic [3:0] crn,
                                        input logic [3:0] crm,
                                        input logic [2:0] op2);
        is_pwr_reg = (crn == CRN_PWR) && (crm == CRM_PWR) &&
                     (op2 == OP2_CTRL || op2 == OP2_PWRDN ||
                      op2 == OP2_STAT);
    endfunction

    function automatic logic [TICK_W-1:0] ret_ticks(input logic [2:0] code);
        ret_ticks = RET_TICKS[code];
    endfunction

    // ==========================================================
    // Register state
    logic [2:0]             ret_code;
    logic [3:0]             ctrl_portion;
    logic [3:0]             stat_portion;
    logic [NUM_THREADS-1:0] pwrdn_clus;
    logic [NUM_THREADS-1:0] pwrdn_mem;
    logic                   loaded;
    logic [2:0]             next_ret_code;
    logic [3:0]             next_ctrl_portion;
    logic [3:0]             next_stat_portion;
    logic [NUM_THREADS-1:0] next_pwrdn_clus;
    logic [NUM_THREADS-1:0] next_pwrdn_mem;
    logic [31:0]            next_rdata;
    logic                   next_ack;
    logic                   next_fault;
    logic                   write_ok;
    logic                   ctrl_written;

    // Kernel level needs both enables, or top enable when secure
    assign write_ok = (I_REG_EL != EL_USER) &&
                      ((I_REG_EL != EL_KERN) ||
                       (I_TOP_PWR_WE && (I_HYP_PWR_WE || !I_NONSECURE)));

    always_comb begin
        next_ret_code     = ret_code;
        next_ctrl_portion = ctrl_portion;
        next_pwrdn_clus   = pwrdn_clus;
        next_pwrdn_mem    = pwrdn_mem;
        next_rdata        = '0;
        next_ack          = 1'b0;
        next_fault        = 1'b0;
        ctrl_written      = 1'b0;
        // Portions follow channel init state until first release edge
        next_stat_portion = loaded ? I_PORTIONS_POWERED
                                   : I_PCH_INIT_PORTIONS;
        if (!loaded) begin
            next_ctrl_portion = I_PCH_INIT_PORTIONS;
        end
        if (I_REG_VALID) begin
            if (!is_pwr_reg(I_REG_CRN, I_REG_CRM, I_REG_OP2) ||
                I_REG_EL == EL_USER) begin
                next_fault = 1'b1;
            end else if (I_REG_WRITE && !write_ok) begin
                next_fault = 1'b1;
            end else begin
                next_ack = 1'b1;
                unique case (I_REG_OP2)
                    OP2_CTRL: begin
                        if (I_REG_WRITE) begin
                            next_ret_code     = I_REG_WDATA[RET_MSB:RET_LSB];
                            next_ctrl_portion = I_REG_WDATA[PORT_MSB:PORT_LSB];
                            ctrl_written      = 1'b1;
                        end else begin
                            next_rdata[RET_MSB:RET_LSB]   = ret_code;
                            next_rdata[PORT_MSB:PORT_LSB] = ctrl_portion;
                        end
                    end
                    OP2_PWRDN: begin
                        if (I_REG_WRITE) begin
                            next_pwrdn_clus[I_REG_THREAD] = I_REG_WDATA[DN_CLUS];
                            next_pwrdn_mem[I_REG_THREAD]  = I_REG_WDATA[DN_MEM];
                        end else begin
                            next_rdata[DN_CLUS] = pwrdn_clus[I_REG_THREAD];
                            next_rdata[DN_MEM]  = pwrdn_mem[I_REG_THREAD];
                        end
                    end
                    OP2_STAT: begin
                        // Writes are accepted and dropped
                        if (!I_REG_WRITE) begin
                            next_rdata[PORT_MSB:PORT_LSB] = stat_portion;
                            next_rdata[DN_MEM]  = |pwrdn_mem;
                            next_rdata[DN_CLUS] = |pwrdn_clus;
                        end
                    end
                    default: begin
                        next_ack   = 1'b0;
                        next_fault = 1'b1;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            ret_code     <= RET_OFF;
            ctrl_portion <= '0;
            stat_portion <= '0;
            pwrdn_clus   <= '0;
            pwrdn_mem    <= '0;
            loaded       <= 1'b0;
            O_REG_RDATA  <= '0;
            O_REG_ACK    <= 1'b0;
            O_REG_FAULT  <= 1'b0;
        end else begin
            ret_code     <= next_ret_code;
            ctrl_portion <= next_ctrl_portion;
            stat_portion <= next_stat_portion;
            pwrdn_clus   <= next_pwrdn_clus;
            pwrdn_mem    <= next_pwrdn_mem;
            loaded       <= 1'b1;
            O_REG_RDATA  <= next_rdata;
            O_REG_ACK    <= next_ack;
            O_REG_FAULT  <= next_fault;
        end
    end

    // ==========================================================
    // Retention inactivity timer
    ret_state_type       ret_state;
    ret_state_type       next_ret_state;
    logic [TICK_W-1:0]   tick_cnt;
    logic [TICK_W-1:0]   next_tick_cnt;
    logic [HINT_W-1:0]   next_hint;

    always_comb begin
        next_ret_state = ret_state;
        next_tick_cnt  = tick_cnt;
        unique case (ret_state)
            RET_IDLE: begin
                next_tick_cnt = '0;
                if (ret_code != RET_OFF && !I_CLUSTER_ACTIVE && !ctrl_written) begin
                    next_ret_state = RET_COUNT;
                end
            end
            RET_COUNT: begin
                if (ret_code == RET_OFF || I_CLUSTER_ACTIVE || ctrl_written) begin
                    next_ret_state = RET_IDLE;
                    next_tick_cnt  = '0;
                end else if (I_TIMER_TICK) begin
                    next_tick_cnt = tick_cnt + TICK_ONE;
                    if (next_tick_cnt >= ret_ticks(ret_code)) begin
                        next_ret_state = RET_REQ;
                    end
                end
            end
            RET_REQ: begin
                if (ret_code == RET_OFF || I_CLUSTER_ACTIVE || ctrl_written) begin
                    next_ret_state = RET_IDLE;
                    next_tick_cnt  = '0;
                end
            end
        endcase
        next_hint = '0;
        next_hint[HINT_PORT_MSB:HINT_PORT_LSB] = next_ctrl_portion;
        next_hint[HINT_RETN] = (next_ret_state == RET_REQ);
        next_hint[HINT_MEM]  = |next_pwrdn_mem;
        next_hint[HINT_CLUS] = |next_pwrdn_clus;
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            ret_state           <= RET_IDLE;
            tick_cnt            <= '0;
            O_POWER_ACTIVE_HINT <= '0;
        end else begin
            ret_state           <= next_ret_state;
            tick_cnt            <= next_tick_cnt;
            O_POWER_ACTIVE_HINT <= next_hint;
        end
    end

    // Hints never block a powerdown request
    assign O_PCH_DOWN_ACCEPT = I_PCH_DOWN_REQ;

    // ==========================================================
    // Checks
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_ARST_N);

    logic [NUM_THREADS-1:0] thr_mask;
    assign thr_mask = {{(NUM_THREADS-1){1'b0}}, 1'b1} << I_REG_THREAD;

    sequence seq_pwrdn_write;
        I_REG_VALID && I_REG_WRITE && write_ok &&
        is_pwr_reg(I_REG_CRN, I_REG_CRM, I_REG_OP2) && I_REG_OP2 == OP2_PWRDN;
    endsequence

    sequence seq_kern_denied;
        I_REG_VALID && I_REG_WRITE && I_REG_EL == EL_KERN &&
        (!I_TOP_PWR_WE || (I_NONSECURE && !I_HYP_PWR_WE));
    endsequence

    sequence seq_stat_read;
        I_REG_VALID && !I_REG_WRITE && I_REG_EL != EL_USER &&
        is_pwr_reg(I_REG_CRN, I_REG_CRM, I_REG_OP2) && I_REG_OP2 == OP2_STAT;
    endsequence

    sequence seq_stat_write;
        loaded && I_REG_VALID && I_REG_WRITE && write_ok &&
        is_pwr_reg(I_REG_CRN, I_REG_CRM, I_REG_OP2) && I_REG_OP2 == OP2_STAT;
    endsequence

    // Tick that brings the count to the programmed threshold while still idle
    sequence seq_ret_due;
        ret_state == RET_COUNT && ret_code != RET_OFF && !I_CLUSTER_ACTIVE &&
        !ctrl_written && I_TIMER_TICK && (tick_cnt + TICK_ONE) >= ret_ticks(ret_code);
    endsequence

    chk_ret_off_idle: assert property (ret_code == RET_OFF |=>
        !O_POWER_ACTIVE_HINT[HINT_RETN])
        else $error("retention requested while disabled");
    chk_ret_threshold: assert property (
        $rose(ret_state == RET_REQ) |->
        ($past(tick_cnt) + TICK_ONE) >= ret_ticks(ret_code) &&
        $past(tick_cnt) < ret_ticks(ret_code))
        else $error("retention entered at wrong tick count");
    chk_ret_hint_state: assert property (
        O_POWER_ACTIVE_HINT[HINT_RETN] == (ret_state == RET_REQ))
        else $error("retention hint disagrees with timer state");
    chk_ret_withdraw: assert property (I_CLUSTER_ACTIVE |=>
        !O_POWER_ACTIVE_HINT[HINT_RETN] && tick_cnt == '0 ##1 tick_cnt == '0)
        else $error("activity did not withdraw retention");
    chk_portion_hint: assert property (
        O_POWER_ACTIVE_HINT[HINT_PORT_MSB:HINT_PORT_LSB] == ctrl_portion)
        else $error("portion hint differs from control field");
    chk_bank_isolate: assert property (seq_pwrdn_write |=>
        ((pwrdn_clus ^ $past(pwrdn_clus)) & ~$past(thr_mask)) == '0 &&
        ((pwrdn_mem ^ $past(pwrdn_mem)) & ~$past(thr_mask)) == '0 &&
        pwrdn_clus[$past(I_REG_THREAD)] == $past(I_REG_WDATA[DN_CLUS]) &&
        pwrdn_mem[$past(I_REG_THREAD)] == $past(I_REG_WDATA[DN_MEM]))
        else $error("banked write leaked to another thread");
    chk_mem_hint: assert property (
        O_POWER_ACTIVE_HINT[HINT_MEM] == |pwrdn_mem)
        else $error("memory retention hint wrong");
    chk_clus_hint: assert property (
        O_POWER_ACTIVE_HINT[HINT_CLUS] == |pwrdn_clus)
        else $error("cluster power hint wrong");
    chk_down_accept: assert property (I_PCH_DOWN_REQ |-> O_PCH_DOWN_ACCEPT)
        else $error("powerdown request refused");
    chk_kern_denied: assert property (seq_kern_denied |=>
        O_REG_FAULT && !O_REG_ACK && $stable(pwrdn_clus) && $stable(ret_code))
        else $error("kernel write not refused");
    chk_stat_combine: assert property (
        seq_stat_read |=> O_REG_ACK &&
        O_REG_RDATA[DN_MEM] == $past(|pwrdn_mem) &&
        O_REG_RDATA[DN_CLUS] == $past(|pwrdn_clus))
        else $error("status combination wrong");
    chk_stat_ignored: assert property (
        seq_stat_write |=> O_REG_ACK && O_REG_RDATA == '0 &&
        $stable(pwrdn_clus) && $stable(pwrdn_mem) &&
        $stable(ret_code) && $stable(ctrl_portion))
        else $error("status write changed state");
    chk_init_portion: assert property (!loaded && !ctrl_written |=>
        ctrl_portion == $past(I_PCH_INIT_PORTIONS) &&
        stat_portion == $past(I_PCH_INIT_PORTIONS))
        else $error("portions did not load channel init state");
    chk_user_fault: assert property (
        I_REG_VALID && I_REG_EL == EL_USER |=> O_REG_FAULT && !O_REG_ACK)
        else $error("lowest level access not refused");
    chk_ret_entry: assert property (seq_ret_due |=>
        O_POWER_ACTIVE_HINT[HINT_RETN])
        else $error("retention not requested at threshold");
endmodule

/* File: verilog/cluster_power_pkg.sv */
// Constants and types for the cluster power control registers
package cluster_power_pkg;
    localparam int NUM_THREADS = 4;
    localparam int THREAD_W    = 2;
    localparam int TICK_W      = 10;
    localparam int HINT_W      = 20;

    // System register coordinates
    localparam logic [3:0] CRN_PWR   = 4'hF;
    localparam logic [3:0] CRM_PWR   = 4'h3;
    localparam logic [2:0] OP2_CTRL  = 3'h5;
    localparam logic [2:0] OP2_PWRDN = 3'h6;
    localparam logic [2:0] OP2_STAT  = 3'h7;

    // Privilege levels
    localparam logic [1:0] EL_USER = 2'h0;
    localparam logic [1:0] EL_KERN = 2'h1;

    // Field positions
    localparam int RET_LSB  = 0;
    localparam int RET_MSB  = 2;
    localparam int PORT_LSB = 4;
    localparam int PORT_MSB = 7;
    localparam int DN_CLUS  = 0;
    localparam int DN_MEM   = 1;

    // Power-active hint bit positions
    localparam int HINT_CLUS     = 0;
    localparam int HINT_RETN     = 1;
    localparam int HINT_MEM      = 2;
    localparam int HINT_PORT_LSB = 16;
    localparam int HINT_PORT_MSB = 19;

    // Reset values and retention thresholds in timer ticks
    localparam logic [2:0]  RET_OFF = 3'h0;
    localparam logic [TICK_W-1:0] RET_TICKS [0:7] = '{
        10'h000, 10'h002, 10'h008, 10'h020,
        10'h040, 10'h080, 10'h100, 10'h200};
    localparam logic [TICK_W-1:0] TICK_ONE = 10'h001;

    typedef enum logic [1:0] {RET_IDLE, RET_COUNT, RET_REQ} ret_state_type;
endpackage

/* File: tb/power_controller_model.sv */
// Behavioural cluster power controller on the far side of the hints
`timescale 1ns/1ps
module power_controller_model
    import cluster_power_pkg::*;
#(
    parameter logic [3:0] INIT_PORTIONS = 4'hF,
    parameter int         LAG           = 4
) (
    input  wire logic              i_clk,
    input  wire logic              i_arst_n,
    input  wire logic [HINT_W-1:0] i_hint,
    input  wire logic              i_down_cmd,
    output logic [3:0]             o_init_portions,
    output logic [3:0]             o_portions,
    output logic                   o_down_req
);
    int wait_cnt;

    assign o_init_portions = INIT_PORTIONS;

    // Powered portions follow the request only after LAG+1 cycles
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_portions <= INIT_PORTIONS;
            wait_cnt   <= 0;
            o_down_req <= 1'h0;
        end else begin
            o_down_req <= i_down_cmd;
            if (o_portions == i_hint[HINT_PORT_MSB:HINT_PORT_LSB]) begin
                wait_cnt <= 0;
            end else if (wait_cnt == LAG) begin
                o_portions <= i_hint[HINT_PORT_MSB:HINT_PORT_LSB];
                wait_cnt   <= 0;
            end else begin
                wait_cnt <= wait_cnt + 1;
            end
        end
    end
endmodule

/* File: tb/testbench.sv */
// Self-checking testbench for the cluster power control registers
`timescale 1ns/1ps
module testbench;
    import cluster_power_pkg::*;
    logic              I_CLK    = 1'h0;
    logic              I_ARST_N = 1'h0;
    logic              valid    = 1'h0;
    logic              wr       = 1'h0;
    logic              top      = 1'h1;
    logic              hyp      = 1'h1;
    logic              ns       = 1'h0;
    logic              tick     = 1'h0;
    logic              active   = 1'h1;
    logic              down_cmd = 1'h0;
    logic [3:0]        crn      = CRN_PWR;
    logic [3:0]        crm      = CRM_PWR;
    logic [2:0]        op2      = 3'h0;
    logic [1:0]        thr      = 2'h0;
    logic [1:0]        el       = 2'h3;
    logic [31:0]       wdata    = 32'h0;
    logic [31:0]       rdata;
    logic              ack;
    logic              fault;
    logic              accept;
    logic              down_req;
    logic [3:0]        init_p;
    logic [3:0]        pow_p;
    logic [HINT_W-1:0] hint;
    int                errors   = 0;
    int                checks   = 0;
    int                tbl [0:7] = '{4, 2, 8, 32, 64, 128, 256, 512};
    logic [5:0]        priv [0:6] = '{6'h0D, 6'h15, 6'h1B, 6'h18, 6'h1E, 6'h22, 6'h32};
    logic [10:0]       bad  [0:2] = '{11'h71D, 11'h795, 11'h79C};

    always #10 I_CLK = ~I_CLK;

    cluster_power_control_regs u_dut (
        .I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .I_REG_VALID(valid), .I_REG_WRITE(wr),
        .I_REG_CRN(crn), .I_REG_CRM(crm), .I_REG_OP2(op2), .I_REG_THREAD(thr),
        .I_REG_EL(el), .I_REG_WDATA(wdata), .I_TOP_PWR_WE(top), .I_HYP_PWR_WE(hyp),
        .I_NONSECURE(ns), .I_TIMER_TICK(tick), .I_CLUSTER_ACTIVE(active),
        .I_PCH_INIT_PORTIONS(init_p), .I_PORTIONS_POWERED(pow_p),
        .I_PCH_DOWN_REQ(down_req), .O_REG_RDATA(rdata), .O_REG_ACK(ack),
        .O_REG_FAULT(fault), .O_PCH_DOWN_ACCEPT(accept), .O_POWER_ACTIVE_HINT(hint));

    power_controller_model #(.INIT_PORTIONS(4'h7)) u_ctrl (
        .i_clk(I_CLK), .i_arst_n(I_ARST_N), .i_hint(hint), .i_down_cmd(down_cmd),
        .o_init_portions(init_p), .o_portions(pow_p), .o_down_req(down_req));

    // ==========================================
    // Access and checking tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge I_CLK);
        #1;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One-cycle request; the answer stands in the cycle after the taken edge
    task automatic acc(input logic w, input logic [1:0] t, input logic [2:0] o,
                       input logic [31:0] d);
        cyc(1);
        valid = 1'h1;
        wr    = w;
        thr   = t;
        op2   = o;
        wdata = d;
        cyc(1);
        valid = 1'h0;
    endtask

    task automatic ticks(input int n);
        repeat (n) begin
            cyc(1);
            tick = 1'h1;
            cyc(1);
            tick = 1'h0;
        end
    endtask

    task automatic conclude();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #200000;
        errors++;
        conclude();
    end

    // ==========================================
    // Test sequence
    initial begin
        cyc(2);
        I_ARST_N = 1'h1;
        cyc(2);
        acc(1'h0, 2'h0, OP2_CTRL, 32'h0);
        check("ctrl reset", rdata, 32'h70);
        check("hint reset", 32'(hint), 32'h70000);
        acc(1'h0, 2'h0, OP2_STAT, 32'h0);
        check("stat reset", rdata, 32'h70);
        for (int t = 0; t < 4; t++) begin
            acc(1'h0, 2'(t), OP2_PWRDN, 32'h0);
            check("pwrdn reset", rdata, 32'h0);
        end
        acc(1'h1, 2'h0, OP2_CTRL, 32'h30);
        cyc(1);
        check("hint portions", 32'(hint), 32'h30000);
        cyc(8);
        acc(1'h0, 2'h0, OP2_STAT, 32'h0);
        check("stat portions", rdata, 32'h30);
        acc(1'h1, 2'h1, OP2_PWRDN, 32'hFFFFFFFE);
        acc(1'h1, 2'h2, OP2_PWRDN, 32'h1);
        for (int t = 0; t < 4; t++) begin
            acc(1'h0, 2'(t), OP2_PWRDN, 32'h0);
            check("pwrdn bank", rdata, (t == 1) ? 32'h2 : (t == 2) ? 32'h1 : 32'h0);
        end
        acc(1'h0, 2'h0, OP2_STAT, 32'h0);
        check("stat or", rdata, 32'h33);
        check("hint pwrdn", 32'(hint), 32'h30005);
        acc(1'h1, 2'h1, OP2_PWRDN, 32'h0);
        cyc(1);
        check("hint mem off", 32'(hint), 32'h30001);
        down_cmd = 1'h1;
        cyc(2);
        check("down accept", 32'(accept), 32'h1);
        down_cmd = 1'h0;
        acc(1'h1, 2'h3, OP2_STAT, 32'hFFFFFFFF);
        check("stat write ack", 32'(ack), 32'h1);
        acc(1'h0, 2'h3, OP2_STAT, 32'h0);
        check("stat unchanged", rdata, 32'h31);
        for (int i = 0; i < 7; i++) begin
            el = 2'h3;
            acc(1'h1, 2'h3, OP2_PWRDN, 32'h0);
            {el, top, hyp, ns} = priv[i][5:1];
            acc(1'h1, 2'h3, OP2_PWRDN, 32'h3);
            check("priv fault", 32'(fault), 32'(priv[i][0]));
            el = 2'h3;
            acc(1'h0, 2'h3, OP2_PWRDN, 32'h0);
            check("priv data", rdata, priv[i][0] ? 32'h0 : 32'h3);
        end
        for (int i = 0; i < 3; i++) begin
            {crn, crm} = bad[i][10:3];
            acc(1'h0, 2'h0, bad[i][2:0], 32'h0);
            check("decode fault", 32'(fault), 32'h1);
        end
        crn = CRN_PWR;
        crm = CRM_PWR;
        for (int k = 0; k < 8; k++) begin
            active = 1'h0;
            acc(1'h1, 2'h0, OP2_CTRL, {24'h0, 4'h3, 1'h0, 3'(k)});
            cyc(1);
            ticks(tbl[k] - 1);
            check("retention early", 32'(hint[HINT_RETN]), 32'h0);
            ticks(1);
            cyc(1);
            check("retention", 32'(hint[HINT_RETN]), 32'(k != 0));
            active = 1'h1;
            cyc(2);
            check("retention drop", 32'(hint[HINT_RETN]), 32'h0);
        end
        conclude();
    end
endmodule
